//--- verilog/capability_pkg.sv
// constants, types and register map of the operation capability register bank
// Behaviour
// - source capabilities read-only at offset 0x1018
// - destination capabilities at 0x101c, same layout
// - bits 31..18 read zero, writes ignored
// - bits 9 and 3 always read zero
// - read and write flags reset zero
// - streaming and acknowledged store flags reset zero
// - message and doorbell flags reset zero
// - test-and-swap and locked op flags reset zero
// - port-write flag is the only one set
// - both vendor fields reset to 00
package capability_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;

    // register byte addresses
    localparam logic [15:0] SOURCE_CAPABILITIES_OFFSET      = 16'h1018;
    localparam logic [15:0] DESTINATION_CAPABILITIES_OFFSET = 16'h101c;
    localparam logic [15:0] ACCESS_CONTROL_OFFSET           = 16'h1010;
    localparam logic [15:0] ACCESS_STATUS_OFFSET            = 16'h1014;
    localparam logic [1:0]  WORD_ALIGN                      = 2'h0;

    // capability word: bit positions of the flags
    localparam int unsigned BIT_READ             = 15;
    localparam int unsigned BIT_WRITE            = 14;
    localparam int unsigned BIT_STREAMING_STORE  = 13;
    localparam int unsigned BIT_ACKED_STORE      = 12;
    localparam int unsigned BIT_MESSAGE          = 11;
    localparam int unsigned BIT_DOORBELL         = 10;
    localparam int unsigned BIT_TEST_AND_SWAP    = 8;
    localparam int unsigned BIT_LOCKED_INCREMENT = 7;
    localparam int unsigned BIT_LOCKED_DECREMENT = 6;
    localparam int unsigned BIT_LOCKED_SET       = 5;
    localparam int unsigned BIT_LOCKED_CLEAR     = 4;
    localparam int unsigned BIT_PORT_WRITE       = 2;
    localparam int unsigned VENDOR_HIGH_LSB      = 16;
    localparam int unsigned VENDOR_LOW_LSB       = 0;
    localparam int unsigned VENDOR_W             = 2;

    // reserved positions (31..18, 9, 3) forced to zero
    localparam logic [31:0] CAPABILITY_RESERVED_MASK = 32'hfffc_0208;

    // operation flag vector, one bit per supported transaction type
    localparam int unsigned OPS_W            = 12;
    localparam int unsigned OP_READ          = 11;
    localparam int unsigned OP_WRITE         = 10;
    localparam int unsigned OP_STREAMING     = 9;
    localparam int unsigned OP_ACKED         = 8;
    localparam int unsigned OP_MESSAGE       = 7;
    localparam int unsigned OP_DOORBELL      = 6;
    localparam int unsigned OP_TEST_AND_SWAP = 5;
    localparam int unsigned OP_INCREMENT     = 4;
    localparam int unsigned OP_DECREMENT     = 3;
    localparam int unsigned OP_SET           = 2;
    localparam int unsigned OP_CLEAR         = 1;
    localparam int unsigned OP_PORT_WRITE    = 0;

    // reset values: only port write is set, vendor fields are 00
    localparam logic [11:0] OPS_RESET          = 12'h001;
    localparam logic [1:0]  VENDOR_LOW_RESET   = 2'h0;
    localparam logic [1:0]  VENDOR_HIGH_RESET  = 2'h0;
    localparam logic [31:0] CAPABILITY_FIXED   = 32'h0000_0004;

    // access control register layout
    localparam int unsigned CTRL_ERR_UNMAPPED_BIT = 0;
    localparam int unsigned CTRL_ERR_RO_WRITE_BIT = 1;
    localparam int unsigned CTRL_WAIT_LSB         = 4;
    localparam int unsigned WAIT_W                = 2;
    localparam logic [7:0]  CTRL_RESET            = 8'h00;
    localparam int unsigned CTRL_W                = 8;

    // access status register layout
    localparam int unsigned ST_IGNORED_BIT     = 0;
    localparam int unsigned ST_UNMAPPED_BIT    = 1;
    localparam int unsigned ST_IGNORED_CNT_LSB = 8;
    localparam int unsigned ST_UNMAPPED_CNT_LSB = 16;
    localparam int unsigned CNT_W              = 8;
    localparam logic [7:0]  CNT_ZERO           = 8'h00;
    localparam logic [7:0]  CNT_ONE            = 8'h01;
    localparam logic [7:0]  CNT_MAX            = 8'hff;
    localparam logic [1:0]  WAIT_ZERO          = 2'h0;
    localparam logic [1:0]  WAIT_ONE           = 2'h1;
    localparam logic [31:0] WORD_ZERO          = 32'h0000_0000;

    // bus transfer phase
    typedef enum logic [0:0] {
        phase_idle   = 1'b0,
        phase_access = 1'b1
    } phase_t;

    // decoded target of a transfer
    typedef enum logic [2:0] {
        tgt_source      = 3'b000,
        tgt_destination = 3'b001,
        tgt_control     = 3'b010,
        tgt_status      = 3'b011,
        tgt_unmapped    = 3'b100
    } target_t;

endpackage

//--- verilog/capability_word.sv
// packs operation flags and vendor fields into one capability word
`timescale 1ns/1ps
module capability_word (
    // flags and fields
    input  wire logic [11:0] ops,
    input  wire logic [1:0]  vendor_field_low,
    input  wire logic [1:0]  vendor_field_high,
    // assembled word
    output logic      [31:0] word
);

    logic [31:0] raw;

    // place each flag at its documented bit
    always_comb begin
        raw = capability_pkg::WORD_ZERO;
        raw[capability_pkg::BIT_READ]             = ops[capability_pkg::OP_READ];
        raw[capability_pkg::BIT_WRITE]            = ops[capability_pkg::OP_WRITE];
        raw[capability_pkg::BIT_STREAMING_STORE]  = ops[capability_pkg::OP_STREAMING];
        raw[capability_pkg::BIT_ACKED_STORE]      = ops[capability_pkg::OP_ACKED];
        raw[capability_pkg::BIT_MESSAGE]          = ops[capability_pkg::OP_MESSAGE];
        raw[capability_pkg::BIT_DOORBELL]         = ops[capability_pkg::OP_DOORBELL];
        raw[capability_pkg::BIT_TEST_AND_SWAP]    = ops[capability_pkg::OP_TEST_AND_SWAP];
        raw[capability_pkg::BIT_LOCKED_INCREMENT] = ops[capability_pkg::OP_INCREMENT];
        raw[capability_pkg::BIT_LOCKED_DECREMENT] = ops[capability_pkg::OP_DECREMENT];
        raw[capability_pkg::BIT_LOCKED_SET]       = ops[capability_pkg::OP_SET];
        raw[capability_pkg::BIT_LOCKED_CLEAR]     = ops[capability_pkg::OP_CLEAR];
        raw[capability_pkg::BIT_PORT_WRITE]       = ops[capability_pkg::OP_PORT_WRITE];
        raw[capability_pkg::VENDOR_HIGH_LSB +: capability_pkg::VENDOR_W] = vendor_field_high;
        raw[capability_pkg::VENDOR_LOW_LSB +: capability_pkg::VENDOR_W]  = vendor_field_low;
    end

    // reserved bits always read zero
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            assign word[i] = raw[i] & ~capability_pkg::CAPABILITY_RESERVED_MASK[i];
        end
    endgenerate

endmodule

//--- verilog/capability_registers.sv
// apb slave holding the source and destination capability registers
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module capability_registers (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    // apb answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // capability contents, fixed from reset on
    logic [11:0] source_ops_reg;
    logic [11:0] destination_ops_reg;
    logic [1:0]  source_vendor_low_reg;
    logic [1:0]  source_vendor_high_reg;
    logic [1:0]  destination_vendor_low_reg;
    logic [1:0]  destination_vendor_high_reg;
    logic [31:0] source_word;
    logic [31:0] destination_word;

    // bus state
    capability_pkg::phase_t  phase_reg;
    capability_pkg::target_t target_reg;
    capability_pkg::target_t target_next;
    logic [1:0]  wait_cnt_reg;
    logic [1:0]  wait_len_reg;
    logic        err_reg;
    logic        err_next;
    logic [31:0] prdata_reg;
    logic [31:0] read_next;

    // control and status
    logic [7:0]  control_reg;
    logic        ignored_flag_reg;
    logic        unmapped_flag_reg;
    logic [7:0]  ignored_cnt_reg;
    logic [7:0]  unmapped_cnt_reg;
    logic [31:0] control_word;
    logic [31:0] status_word;

    // transfer events
    logic        setup;
    logic        capture;
    logic        complete;
    logic        write_done;
    logic        ctrl_write;
    logic        status_write;
    logic        ignored_event;
    logic        unmapped_event;
    logic        clear_ignored;
    logic        clear_unmapped;

    // capability words assembled per register
    capability_word u_source_word (
        .ops               (source_ops_reg),
        .vendor_field_low  (source_vendor_low_reg),
        .vendor_field_high (source_vendor_high_reg),
        .word              (source_word)
    );

    capability_word u_destination_word (
        .ops               (destination_ops_reg),
        .vendor_field_low  (destination_vendor_low_reg),
        .vendor_field_high (destination_vendor_high_reg),
        .word              (destination_word)
    );

    // capability contents take their fixed values at reset; no path writes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_ops_reg              <= capability_pkg::OPS_RESET;
            destination_ops_reg         <= capability_pkg::OPS_RESET;
            source_vendor_low_reg       <= capability_pkg::VENDOR_LOW_RESET;
            source_vendor_high_reg      <= capability_pkg::VENDOR_HIGH_RESET;
            destination_vendor_low_reg  <= capability_pkg::VENDOR_LOW_RESET;
            destination_vendor_high_reg <= capability_pkg::VENDOR_HIGH_RESET;
        end else begin
            source_ops_reg              <= source_ops_reg;
            destination_ops_reg         <= destination_ops_reg;
            source_vendor_low_reg       <= source_vendor_low_reg;
            source_vendor_high_reg      <= source_vendor_high_reg;
            destination_vendor_low_reg  <= destination_vendor_low_reg;
            destination_vendor_high_reg <= destination_vendor_high_reg;
        end
    end

    // phase events of the apb transfer
    assign setup    = psel && !penable;
    assign capture  = setup && (phase_reg == capability_pkg::phase_idle);
    assign pready   = (phase_reg == capability_pkg::phase_access)
                      && (wait_cnt_reg == wait_len_reg);
    assign complete = psel && penable && pready;
    assign pslverr  = pready && err_reg;
    assign prdata   = prdata_reg;

    // address decode, misaligned addresses count as unmapped
    always_comb begin
        target_next = capability_pkg::tgt_unmapped;
        if (paddr[1:0] == capability_pkg::WORD_ALIGN) begin
            unique case (paddr)
                capability_pkg::SOURCE_CAPABILITIES_OFFSET: begin
                    target_next = capability_pkg::tgt_source;
                end
                capability_pkg::DESTINATION_CAPABILITIES_OFFSET: begin
                    target_next = capability_pkg::tgt_destination;
                end
                capability_pkg::ACCESS_CONTROL_OFFSET: begin
                    target_next = capability_pkg::tgt_control;
                end
                capability_pkg::ACCESS_STATUS_OFFSET: begin
                    target_next = capability_pkg::tgt_status;
                end
                default: begin
                    target_next = capability_pkg::tgt_unmapped;
                end
            endcase
        end
    end

    // readable images of control and status
    always_comb begin
        control_word = capability_pkg::WORD_ZERO;
        control_word[capability_pkg::CTRL_W-1:0] = control_reg;
        status_word  = capability_pkg::WORD_ZERO;
        status_word[capability_pkg::ST_IGNORED_BIT]  = ignored_flag_reg;
        status_word[capability_pkg::ST_UNMAPPED_BIT] = unmapped_flag_reg;
        status_word[capability_pkg::ST_IGNORED_CNT_LSB +: capability_pkg::CNT_W]  =
            ignored_cnt_reg;
        status_word[capability_pkg::ST_UNMAPPED_CNT_LSB +: capability_pkg::CNT_W] =
            unmapped_cnt_reg;
    end

    // read data and error chosen in the setup cycle
    always_comb begin
        read_next = capability_pkg::WORD_ZERO;
        err_next  = 1'b0;
        unique case (target_next)
            capability_pkg::tgt_source: begin
                read_next = source_word;
                err_next  = pwrite && control_reg[capability_pkg::CTRL_ERR_RO_WRITE_BIT];
            end
            capability_pkg::tgt_destination: begin
                read_next = destination_word;
                err_next  = pwrite && control_reg[capability_pkg::CTRL_ERR_RO_WRITE_BIT];
            end
            capability_pkg::tgt_control: begin
                read_next = control_word;
            end
            capability_pkg::tgt_status: begin
                read_next = status_word;
            end
            capability_pkg::tgt_unmapped: begin
                read_next = capability_pkg::WORD_ZERO;
                err_next  = control_reg[capability_pkg::CTRL_ERR_UNMAPPED_BIT];
            end
            default: begin
                read_next = capability_pkg::WORD_ZERO;
                err_next  = 1'b0;
            end
        endcase
        if (pwrite) begin
            read_next = capability_pkg::WORD_ZERO;
        end
    end

    // transfer phase: setup moves to access, completion returns to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= capability_pkg::phase_idle;
        end else begin
            unique case (phase_reg)
                capability_pkg::phase_idle: begin
                    if (setup) begin
                        phase_reg <= capability_pkg::phase_access;
                    end
                end
                capability_pkg::phase_access: begin
                    if (pready) begin
                        phase_reg <= capability_pkg::phase_idle;
                    end
                end
            endcase
        end
    end

    // decoded target held for the write effects at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_reg <= capability_pkg::tgt_unmapped;
        end else if (capture) begin
            target_reg <= target_next;
        end
    end

    // error and read data captured at setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg    <= 1'b0;
            prdata_reg <= capability_pkg::WORD_ZERO;
        end else if (capture) begin
            err_reg    <= err_next;
            prdata_reg <= read_next;
        end
    end

    // wait length taken at setup, so a control write affects the next transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_len_reg <= capability_pkg::WAIT_ZERO;
        end else if (capture) begin
            wait_len_reg <= control_reg[capability_pkg::CTRL_WAIT_LSB +: capability_pkg::WAIT_W];
        end
    end

    // wait states counted through the access phase until ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_reg <= capability_pkg::WAIT_ZERO;
        end else if (capture) begin
            wait_cnt_reg <= capability_pkg::WAIT_ZERO;
        end else if ((phase_reg == capability_pkg::phase_access) && !pready) begin
            wait_cnt_reg <= wait_cnt_reg + capability_pkg::WAIT_ONE;
        end
    end

    // write effects only at the completing edge
    assign write_done     = complete && pwrite;
    assign ctrl_write     = write_done && (target_reg == capability_pkg::tgt_control)
                            && pstrb[0];
    assign status_write   = write_done && (target_reg == capability_pkg::tgt_status)
                            && pstrb[0];
    assign ignored_event  = write_done && ((target_reg == capability_pkg::tgt_source)
                            || (target_reg == capability_pkg::tgt_destination));
    assign unmapped_event = complete && (target_reg == capability_pkg::tgt_unmapped);
    assign clear_ignored  = status_write && pwdata[capability_pkg::ST_IGNORED_BIT];
    assign clear_unmapped = status_write && pwdata[capability_pkg::ST_UNMAPPED_BIT];

    // access control register, low byte lane only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= capability_pkg::CTRL_RESET;
        end else if (ctrl_write) begin
            control_reg <= pwdata[capability_pkg::CTRL_W-1:0];
        end
    end

    // ignored-write flag: a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ignored_flag_reg <= 1'b0;
        end else if (ignored_event) begin
            ignored_flag_reg <= 1'b1;
        end else if (clear_ignored) begin
            ignored_flag_reg <= 1'b0;
        end
    end

    // ignored-write count: saturates, restarts at one when an event meets a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ignored_cnt_reg <= capability_pkg::CNT_ZERO;
        end else if (ignored_event && clear_ignored) begin
            ignored_cnt_reg <= capability_pkg::CNT_ONE;
        end else if (ignored_event && (ignored_cnt_reg != capability_pkg::CNT_MAX)) begin
            ignored_cnt_reg <= ignored_cnt_reg + capability_pkg::CNT_ONE;
        end else if (clear_ignored) begin
            ignored_cnt_reg <= capability_pkg::CNT_ZERO;
        end
    end

    // unmapped-access flag: a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unmapped_flag_reg <= 1'b0;
        end else if (unmapped_event) begin
            unmapped_flag_reg <= 1'b1;
        end else if (clear_unmapped) begin
            unmapped_flag_reg <= 1'b0;
        end
    end

    // unmapped-access count: saturates, restarts at one when an event meets a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unmapped_cnt_reg <= capability_pkg::CNT_ZERO;
        end else if (unmapped_event && clear_unmapped) begin
            unmapped_cnt_reg <= capability_pkg::CNT_ONE;
        end else if (unmapped_event && (unmapped_cnt_reg != capability_pkg::CNT_MAX)) begin
            unmapped_cnt_reg <= unmapped_cnt_reg + capability_pkg::CNT_ONE;
        end else if (clear_unmapped) begin
            unmapped_cnt_reg <= capability_pkg::CNT_ZERO;
        end
    end

endmodule

//--- tb/capability_registers_props.sv
// checker for the capability register bank apb slave, with its bind
`timescale 1ns/1ps
module capability_registers_props (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb request
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // setup cycle, a completed read of one address, a completed capability read
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s(logic [15:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence
    sequence cap_done_s;
        psel && penable && pready && !pwrite && (paddr == 16'h1018 || paddr == 16'h101c);
    endsequence

    src_value_a: assert property (done_s(16'h1018) |-> prdata == 32'h0000_0004)
        else $error("source capability word wrong");
    dst_value_a: assert property (done_s(16'h101c) |-> prdata == 32'h0000_0004)
        else $error("destination capability word wrong");
    high_reserved_a: assert property (cap_done_s |-> prdata[31:18] == 14'h0)
        else $error("capability bits 31 to 18 not zero");
    mid_reserved_a: assert property (cap_done_s |-> !prdata[9] && !prdata[3])
        else $error("capability bit 9 or 3 set");
    rw_flags_a: assert property (cap_done_s |-> prdata[15:14] == 2'h0)
        else $error("read or write flag set");
    store_flags_a: assert property (cap_done_s |-> prdata[13:12] == 2'h0)
        else $error("store flags set");
    msg_flags_a: assert property (cap_done_s |-> prdata[11:10] == 2'h0)
        else $error("message or doorbell flag set");
    atomic_flags_a: assert property (cap_done_s |-> prdata[8:4] == 5'h00)
        else $error("locked operation flags set");
    vendor_zero_a: assert property (cap_done_s |-> {prdata[17:16], prdata[1:0]} == 4'h0)
        else $error("vendor fields not zero");
    ready_bound_a: assert property (setup_s |=> ##[0:3] (pready && penable))
        else $error("no ready within four cycles of setup");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready
        && (pwrite || (paddr != 16'h1018 && paddr != 16'h101c)))
        else $error("error response without ready or on a capability read");
endmodule

bind capability_registers capability_registers_props props_u (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
);

//--- tb/apb_host.sv
// apb host model issuing configuration reads and writes
`timescale 1ns/1ps
module apb_host (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [15:0] paddr,
    output logic      [31:0] pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0;
        pwdata  = 32'h0;
    end

    // one transfer; more keeps psel up so the next setup follows at once
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        input logic more, output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // ready, data and error are taken only at the rising edge that completes
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        if (!more) begin
            // released lines show the inverse, not the last value
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= ~wr;
            paddr   <= ~a;
            pwdata  <= ~d;
            @(posedge pclk);
        end
    endtask
endmodule

//--- tb/capability_registers_tb_top.sv
// testbench for the capability register bank
`timescale 1ns/1ps
module capability_registers_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    int          bad_count;
    int          n_compared;
    localparam logic [31:0] CAP_EXP = 32'h0000_0004; // only port write set

    // design and host
    capability_registers dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 50 ns clock
    always #25 pclk = ~pclk;

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic rw(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      input logic more);
        host_u.xfer(wr, a, d, more, rd, err);
    endtask

    // both words after reset, read back to back, field by field
    task automatic t_reset_values();
        for (int i = 0; i < 2; i++) begin
            rw(1'b0, (i == 0) ? 16'h1018 : 16'h101c, 32'h0, i == 0);
            check(CAP_EXP, rd);
            check(32'(rd[31:18]), 32'h0);
            check(32'({rd[9], rd[3]}), 32'h0);
            check(32'(rd[15:14]), 32'h0);
            check(32'(rd[13:12]), 32'h0);
            check(32'(rd[11:10]), 32'h0);
            check(32'(rd[8:4]), 32'h0);
            check(32'({rd[17:16], rd[1:0]}), 32'h0);
            check(32'(err), 32'h0);
        end
    endtask

    // all-ones writes leave both words unchanged
    task automatic t_write_ignored();
        rw(1'b1, 16'h1018, 32'hffff_ffff, 1'b1);
        check(32'(err), 32'h0);
        rw(1'b1, 16'h101c, 32'hffff_ffff, 1'b1);
        rw(1'b0, 16'h1018, 32'h0, 1'b1);
        check(CAP_EXP, rd);
        rw(1'b0, 16'h101c, 32'h0, 1'b0);
        check(CAP_EXP, rd);
    endtask

    // error reporting and three wait states enabled
    task automatic t_error_modes();
        rw(1'b1, 16'h1010, 32'h33, 1'b0);
        pstrb <= 4'he; // low lane off: this control write is dropped
        rw(1'b1, 16'h1010, 32'h0, 1'b0);
        pstrb <= 4'hf;
        rw(1'b0, 16'h1010, 32'h0, 1'b0);
        check(32'h33, rd);
        rw(1'b1, 16'h1018, 32'h0, 1'b0);
        check(32'h1, 32'(err));
        rw(1'b0, 16'h2000, 32'h0, 1'b0);
        check(32'h0, rd);
        check(32'h1, 32'(err));
        rw(1'b0, 16'h1019, 32'h0, 1'b0);
        check(32'h0, rd);
        rw(1'b0, 16'h101c, 32'h0, 1'b0);
        check(CAP_EXP, rd);
        check(32'h0, 32'(err));
        rw(1'b0, 16'h1014, 32'h0, 1'b0);
        check(32'h3, 32'(rd[1:0]));
        rw(1'b1, 16'h1014, 32'h3, 1'b0);
        rw(1'b0, 16'h1014, 32'h0, 1'b0);
        check(32'h0, rd);
    endtask

    // second reset in mid-run restores control and the source word
    task automatic t_mid_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rw(1'b0, 16'h1010, 32'h0, 1'b1);
        check(32'h0, rd);
        rw(1'b0, 16'h1018, 32'h0, 1'b0);
        check(CAP_EXP, rd);
    endtask

    // reset, then the scenarios
    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        pstrb      = 4'hf;
        pprot      = 3'h0;
        bad_count  = 0;
        n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_write_ignored();
        t_error_modes();
        t_mid_reset();
        summarize();
    end

    // watchdog against a hung transfer
    initial begin
        repeat (2000) @(posedge pclk);
        bad_count++;
        summarize();
    end
endmodule
